//--- rtl/sfe_top.sv
// vector fp exception unit: per-element qualification, flags and trap
// assumes: datapath hands over a finished instruction; avalon-mm master
//
// Overview of operation
// - with non-trapping mode set, no trap is ever raised, unimplemented included.
// - non-trapping mode leaves the enable field as is; it still picks tagged elements.
// - elements are qualified one by one; cause field starts each instruction cleared.
// - no enabled cause at the end: or cause into flags; else trap, flags kept.
// - enable mask is programmed enables plus unimplemented; E=20 O=04 U=02 I=01.
// - overflow with overflow not enabled also sets inexact for that element.
// - underflow not enabled and no inexact drops the underflow cause.
// - no enabled cause: record causes, write result or disabled default.
// - enabled cause, trapping mode: record causes, leave destination unwritten.
// - enabled cause, non-trapping: cause untouched, write tagged signalling nan.
// - disabled overflow default follows the rounding mode.
// - divide by zero gives signed infinity; underflow, inexact give rounded result.
// - disabled invalid gives default quiet nan or the quieted signalling operand.
// - non-trapping enabled exception gives signalling nan with its cause bit.
// - signalling nan patterns per format, low byte carries the cause.
// - nan results carry the payload of the first signalling nan operand, else the first quiet one, left to right.
// - signalling nan operands raise invalid and win over quiet ones.
// - quieting keeps sign, copies mantissa from top, forces exponent and msb.
// - flush mode zeroes subnormal inputs and tiny results, no unimplemented.
// - flushed tiny results raise underflow and inexact except approx reciprocals.
// - flushed subnormal inputs raise inexact except in comparisons.
// - half precision and non-arithmetic operands are never flushed.
// - tagged nan low six bits follow the cause field layout, E at bit 5.
// - the trap carries exception code 0e and reads its reason from cause.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`include "sfe_params.svh"
module sfe_top
  import sfe_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // instruction from the datapath
  input wire logic op_valid,
  output logic op_ready,
  input wire sfe_op_s op,
  // destination writeback
  output logic res_valid,
  output logic [127:0] res_data,
  output logic [7:0] res_wmask,
  // trap to the pipeline
  output logic simd_fp_trap,
  output logic [4:0] trap_code,
  output logic [5:0] trap_cause
);
  // ----------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] sfe_lane(input logic [127:0] v, input sfe_fmt_t f,
                                           input logic [2:0] i);
    logic [127:0] s;
    case (f)
      `SFE_FMT_H: s = (v >> {i, 4'h0}) & {112'h0, 16'hFFFF};
      `SFE_FMT_W: s = (v >> {i, 5'h00}) & {96'h0, 32'hFFFF_FFFF};
      default: s = v >> {i, 6'h00};
    endcase
    return s[63:0];
  endfunction

  function automatic logic [127:0] sfe_put(input logic [127:0] v, input logic [63:0] e,
                                           input sfe_fmt_t f, input logic [2:0] i);
    logic [127:0] m;
    logic [127:0] x;
    case (f)
      `SFE_FMT_H:
      begin
        m = {112'h0, 16'hFFFF} << {i, 4'h0};
        x = {64'h0, e} << {i, 4'h0};
      end
      `SFE_FMT_W:
      begin
        m = {96'h0, 32'hFFFF_FFFF} << {i, 5'h00};
        x = {64'h0, e} << {i, 5'h00};
      end
      default:
      begin
        m = {64'h0, 64'hFFFF_FFFF_FFFF_FFFF} << {i, 6'h00};
        x = {64'h0, e} << {i, 6'h00};
      end
    endcase
    return (v & ~m) | (x & m);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfe_st_s st_r;
  sfe_st_s st_nxt;
  sfe_eout_s eo;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_wr;
  logic [4:0] flag_clr;
  logic [4:0] flag_set;
  logic bus_req;
  logic bus_wr;
  logic en_hit;

  // ----------------------------------------------------------------
  // element stage, one element per cycle
  // ----------------------------------------------------------------
  sfe_elem u_elem (
    .mode(st_r.cur),
    .fmt(st_r.op.fmt),
    .src_fmt(st_r.op.src_fmt),
    .nsrc(st_r.op.nsrc),
    .cls(st_r.op.cls),
    .a(sfe_lane(st_r.op.a, st_r.op.src_fmt, st_r.idx)),
    .b(sfe_lane(st_r.op.b, st_r.op.src_fmt, st_r.idx)),
    .c(sfe_lane(st_r.op.c, st_r.op.src_fmt, st_r.idx)),
    .r(sfe_lane(st_r.op.r, st_r.op.fmt, st_r.idx)),
    .exc(st_r.op.exc[st_r.idx]),
    .tiny(st_r.op.tiny[st_r.idx]),
    .eo(eo)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.res_valid = 1'b0;
    st_nxt.trap = 1'b0;
    bus_req = avs_read | avs_write;
    // one wait cycle: the answer is built while waitrequest is high
    st_nxt.ack = bus_req && !st_r.ack;
    bus_wr = st_r.ack && avs_write;
    ctrl_word = `SFE_CTRL_RST;
    ctrl_word[`SFE_CTRL_EN_MSB:0] = st_r.csr.en;
    ctrl_word[`SFE_CTRL_NX] = st_r.csr.nx;
    ctrl_word[`SFE_CTRL_FS] = st_r.csr.fs;
    ctrl_word[`SFE_CTRL_RM_LSB+:2] = st_r.csr.rm;
    ctrl_wr = ctrl_word;
    for (int k = 0; k < 4; k++)
    begin
      if (avs_byteenable[k])
        ctrl_wr[8*k+:8] = avs_writedata[8*k+:8];
    end
    if (bus_wr && avs_address[3:2] == `SFE_OFF_CTRL >> 2)
    begin
      // each field stands alone; nx does not touch the enables
      st_nxt.csr.en = ctrl_wr[`SFE_CTRL_EN_MSB:0];
      st_nxt.csr.nx = ctrl_wr[`SFE_CTRL_NX];
      st_nxt.csr.fs = ctrl_wr[`SFE_CTRL_FS];
      st_nxt.csr.rm = ctrl_wr[`SFE_CTRL_RM_LSB+:2];
    end
    flag_clr = 5'h00;
    if (bus_wr && avs_address[3:2] == `SFE_OFF_FLAGS >> 2 && avs_byteenable[0])
      flag_clr = avs_writedata[4:0];
    if (bus_req && !st_r.ack)
    begin
      case (avs_address[3:2])
        `SFE_OFF_CTRL >> 2: st_nxt.rdata = ctrl_word;
        `SFE_OFF_FLAGS >> 2: st_nxt.rdata = {27'h0, st_r.flags};
        `SFE_OFF_CAUSE >> 2: st_nxt.rdata = {26'h0, st_r.last_cause};
        `SFE_OFF_STAT >> 2: st_nxt.rdata = {31'h0, st_r.state != SFE_IDLE};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    flag_set = 5'h00;
    en_hit = (st_r.cause & {1'b1, st_r.cur.en}) != 6'h00;
    case (st_r.state)
      SFE_IDLE:
      begin
        if (op_valid)
        begin
          st_nxt.op = op;
          // mode held steady for the whole instruction
          st_nxt.cur = st_r.csr;
          st_nxt.cause = 6'h00;
          st_nxt.idx = 3'h0;
          st_nxt.dest = 128'h0;
          st_nxt.wmask = 8'h00;
          case (op.fmt)
            `SFE_FMT_H: st_nxt.last = `SFE_LAST_H;
            `SFE_FMT_W: st_nxt.last = `SFE_LAST_W;
            default: st_nxt.last = `SFE_LAST_D;
          endcase
          st_nxt.state = SFE_RUN;
        end
      end
      SFE_RUN:
      begin
        st_nxt.cause = st_r.cause | eo.acc;
        if (eo.wr)
        begin
          st_nxt.dest = sfe_put(st_r.dest, eo.val, st_r.op.fmt, st_r.idx);
          st_nxt.wmask[st_r.idx] = 1'b1;
        end
        st_nxt.idx = st_r.idx + 3'h1;
        if (st_r.idx == st_r.last)
          st_nxt.state = SFE_FIN;
      end
      SFE_FIN:
      begin
        if (!en_hit)
          flag_set = st_r.cause[4:0];
        else
          st_nxt.trap = !st_r.cur.nx;
        st_nxt.last_cause = st_r.cause;
        st_nxt.res_valid = 1'b1;
        st_nxt.state = SFE_IDLE;
      end
      default: st_nxt.state = SFE_IDLE;
    endcase
    // a flag raised in the cycle it is cleared survives
    st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
  assign avs_readdata = st_r.rdata;
  assign op_ready = st_r.state == SFE_IDLE;
  assign res_valid = st_r.res_valid;
  assign res_data = st_r.dest;
  assign res_wmask = st_r.wmask;
  assign simd_fp_trap = st_r.trap;
  assign trap_code = `SFE_EXC_CODE;
  assign trap_cause = st_r.last_cause;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_NX_NEVER_TRAPS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    simd_fp_trap |-> !st_r.cur.nx)
    else $error("trap raised in non-trapping mode");

  AST_CAUSE_CLEARED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_ready |=> st_r.cause == 6'h00 && st_r.state == SFE_RUN)
    else $error("cause not cleared at instruction start");

  AST_RESULT_LATENCY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_ready |-> ##[4:10] res_valid)
    else $error("result not delivered in time");

  AST_FLAGS_ACCUMULATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.state == SFE_FIN && !en_hit && flag_clr == 5'h00
    |=> st_r.flags == ($past(st_r.flags) | $past(st_r.cause[4:0])) && !simd_fp_trap)
    else $error("flags not updated from cause");

  AST_TRAP_KEEPS_FLAGS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.state == SFE_FIN && en_hit && !st_r.cur.nx && flag_clr == 5'h00
    |=> simd_fp_trap && st_r.flags == $past(st_r.flags))
    else $error("trap missing or flags changed");

  AST_TRAP_REASON: assert property (@(posedge ref_clk) disable iff (sys_rst)
    simd_fp_trap |-> trap_code == 5'h0E && trap_cause != 6'h00 && op_ready)
    else $error("trap code or reason wrong");

  AST_OVF_INEXACT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.state == SFE_RUN && st_r.op.exc[st_r.idx][`SFE_C_O] && !st_r.cur.en[`SFE_C_O]
    && eo.acc != 6'h00 |-> eo.acc[`SFE_C_I])
    else $error("overflow without inexact");

  AST_TRAP_NO_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.state == SFE_RUN && eo.hit |-> !eo.wr ##1 !st_r.wmask[$past(st_r.idx)])
    else $error("faulting element written in trapping mode");

  AST_NX_TAGGED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.state == SFE_RUN && st_r.cur.nx && !st_r.cur.fs
    && (st_r.op.exc[st_r.idx] & {1'b1, st_r.cur.en}) != 6'h00
    |-> eo.wr && eo.acc == 6'h00 && eo.val[5:0] != 6'h00 && !eo.val[51])
    else $error("non-trapping element not tagged");

endmodule

//--- rtl/sfe_params.svh
// offsets, field positions, reset values and fixed codes
// assumes: included by its bare name from rtl files
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH
`define SFE_OFF_CTRL 4'h0
`define SFE_OFF_FLAGS 4'h4
`define SFE_OFF_CAUSE 4'h8
`define SFE_OFF_STAT 4'hC
`define SFE_CTRL_EN_MSB 4
`define SFE_CTRL_NX 8
`define SFE_CTRL_FS 9
`define SFE_CTRL_RM_LSB 10
`define SFE_CTRL_RST 32'h0000_0000
`define SFE_C_E 5
`define SFE_C_V 4
`define SFE_C_Z 3
`define SFE_C_O 2
`define SFE_C_U 1
`define SFE_C_I 0
`define SFE_FMT_H 2'h1
`define SFE_FMT_W 2'h2
`define SFE_FMT_D 2'h3
`define SFE_RM_NEAR 2'h0
`define SFE_RM_ZERO 2'h1
`define SFE_RM_PLUS 2'h2
`define SFE_RM_MINUS 2'h3
`define SFE_QNAN_H 16'h7E00
`define SFE_QNAN_W 32'h7FC0_0000
`define SFE_QNAN_D 64'h7FF8_0000_0000_0000
`define SFE_SNAN_H 16'h7C00
`define SFE_SNAN_W 32'h7F80_0000
`define SFE_SNAN_D 64'h7FF0_0000_0000_0000
`define SFE_EXC_CODE 5'h0E
`define SFE_LAST_H 3'h7
`define SFE_LAST_W 3'h3
`define SFE_LAST_D 3'h1
`endif

//--- rtl/sfe_pkg.sv
// types shared by the exception unit and its element stage
// assumes: compiled before every other rtl file
package sfe_pkg;
  typedef logic [1:0] sfe_fmt_t;
  typedef logic [5:0] sfe_cause_t;
  typedef struct packed {
    logic is_cmp;
    logic is_recip;
    logic non_arith;
    logic fp_dest;
  } sfe_cls_s;
  typedef struct packed {
    sfe_fmt_t fmt;
    sfe_fmt_t src_fmt;
    logic [1:0] nsrc;
    sfe_cls_s cls;
    logic [127:0] a;
    logic [127:0] b;
    logic [127:0] c;
    logic [127:0] r;
    logic [7:0][5:0] exc;
    logic [7:0] tiny;
  } sfe_op_s;
  typedef struct packed {
    logic [4:0] en;
    logic nx;
    logic fs;
    logic [1:0] rm;
  } sfe_mode_s;
  typedef struct packed {
    logic [63:0] val;
    logic wr;
    sfe_cause_t acc;
    logic hit;
  } sfe_eout_s;
  typedef enum logic [1:0] {SFE_IDLE, SFE_RUN, SFE_FIN} sfe_state_e;
  typedef struct packed {
    sfe_state_e state;
    logic [2:0] idx;
    logic [2:0] last;
    sfe_op_s op;
    sfe_mode_s csr;
    sfe_mode_s cur;
    sfe_cause_t cause;
    sfe_cause_t last_cause;
    logic [4:0] flags;
    logic [127:0] dest;
    logic [7:0] wmask;
    logic ack;
    logic [31:0] rdata;
    logic res_valid;
    logic trap;
  } sfe_st_s;
endpackage

//--- rtl/sfe_elem.sv
// one vector element: flushing, nan choice, cause qualification, value pick
// assumes: lanes zero-extended to 64 bits, purely combinational
`include "sfe_params.svh"
module sfe_elem
  import sfe_pkg::*;
(
  // mode and instruction
  input wire sfe_mode_s mode,
  input wire sfe_fmt_t fmt,
  input wire sfe_fmt_t src_fmt,
  input wire logic [1:0] nsrc,
  input wire sfe_cls_s cls,
  // lane data
  input wire logic [63:0] a,
  input wire logic [63:0] b,
  input wire logic [63:0] c,
  input wire logic [63:0] r,
  input wire sfe_cause_t exc,
  input wire logic tiny,
  // answer
  output sfe_eout_s eo
);
  // {sign, exp ones, exp zero, mant nonzero, mant msb}
  function automatic logic [4:0] sfe_kind(input logic [63:0] x, input sfe_fmt_t f);
    case (f)
      `SFE_FMT_H: return {x[15], &x[14:10], ~|x[14:10], |x[9:0], x[9]};
      `SFE_FMT_W: return {x[31], &x[30:23], ~|x[30:23], |x[22:0], x[22]};
      default: return {x[63], &x[62:52], ~|x[62:52], |x[51:0], x[51]};
    endcase
  endfunction
  // mantissa copied from the top, zero fill or drop at the bottom
  function automatic logic [63:0] sfe_quiet(input logic [63:0] x, input sfe_fmt_t sf,
                                            input sfe_fmt_t df);
    logic s;
    logic [4:0] k;
    logic [51:0] m;
    k = sfe_kind(x, sf);
    s = k[4];
    case (sf)
      `SFE_FMT_H: m = {x[9:0], 42'h0};
      `SFE_FMT_W: m = {x[22:0], 29'h0};
      default: m = x[51:0];
    endcase
    case (df)
      `SFE_FMT_H: return {48'h0, s, 5'h1F, 1'b1, m[50:42]};
      `SFE_FMT_W: return {32'h0, s, 8'hFF, 1'b1, m[50:29]};
      default: return {s, 11'h7FF, 1'b1, m[50:0]};
    endcase
  endfunction
  // infinity when big, else largest finite
  function automatic logic [63:0] sfe_edge(input sfe_fmt_t f, input logic s, input logic big);
    case (f)
      `SFE_FMT_H: return {48'h0, s, 4'hF, big, {10{~big}}};
      `SFE_FMT_W: return {32'h0, s, 7'h7F, big, {23{~big}}};
      default: return {s, 10'h3FF, big, {52{~big}}};
    endcase
  endfunction
  logic [4:0] ka, kb, kc, kr;
  logic va, vb, vc, sa, sb, sc, qa, qb, qc, has_snan, sub_in, flush_on, rs;
  logic [63:0] pick, rr, d, qdef, sbase;
  sfe_cause_t cr, cx, en6, cause;
  always_comb
  begin
    ka = sfe_kind(a, src_fmt);
    kb = sfe_kind(b, src_fmt);
    kc = sfe_kind(c, src_fmt);
    va = 1'b1;
    vb = nsrc >= 2'h2;
    vc = nsrc == 2'h3;
    sa = va & ka[3] & ka[1] & ~ka[0];
    sb = vb & kb[3] & kb[1] & ~kb[0];
    sc = vc & kc[3] & kc[1] & ~kc[0];
    qa = va & ka[3] & ka[0];
    qb = vb & kb[3] & kb[0];
    qc = vc & kc[3] & kc[0];
    has_snan = sa | sb | sc;
    // signalling operands outrank quiet ones, then left to right
    pick = sa ? a : sb ? b : sc ? c : qa ? a : qb ? b : c;
    sub_in = (ka[2] & ka[1]) | (vb & kb[2] & kb[1]) | (vc & kc[2] & kc[1]);
    case (fmt)
      `SFE_FMT_H: begin qdef = {48'h0, `SFE_QNAN_H}; sbase = {48'h0, `SFE_SNAN_H}; end
      `SFE_FMT_W: begin qdef = {32'h0, `SFE_QNAN_W}; sbase = {32'h0, `SFE_SNAN_W}; end
      default: begin qdef = `SFE_QNAN_D; sbase = `SFE_SNAN_D; end
    endcase
    cr = exc;
    rr = r;
    if (cls.fp_dest && (has_snan | qa | qb | qc))
      rr = sfe_quiet(pick, src_fmt, fmt);
    if (has_snan)
      cr[`SFE_C_V] = 1'b1;
    // half precision and non-arithmetic operands are left alone
    flush_on = mode.fs && fmt != `SFE_FMT_H && src_fmt != `SFE_FMT_H && !cls.non_arith;
    if (flush_on)
    begin
      cr[`SFE_C_E] = 1'b0;
      if (sub_in && !cls.is_cmp)
        cr[`SFE_C_I] = 1'b1;
      if (tiny)
      begin
        kr = sfe_kind(r, fmt);
        rr = sfe_edge(fmt, kr[4], 1'b0) & {64{1'b0}} | ({63'h0, kr[4]} << (fmt == `SFE_FMT_H
             ? 7'd15 : fmt == `SFE_FMT_W ? 7'd31 : 7'd63));
        if (!cls.is_recip)
          cr[`SFE_C_U] = 1'b1;
        if (!cls.is_recip)
          cr[`SFE_C_I] = 1'b1;
      end
    end
    en6 = {1'b1, mode.en};
    cx = cr;
    if (cx[`SFE_C_O] && !en6[`SFE_C_O])
      cx[`SFE_C_I] = 1'b1;
    if (cx[`SFE_C_U] && !en6[`SFE_C_U] && !cx[`SFE_C_I])
      cx[`SFE_C_U] = 1'b0;
    kr = sfe_kind(rr, fmt);
    rs = kr[4];
    if (cx[`SFE_C_V])
      d = has_snan ? sfe_quiet(pick, src_fmt, fmt) : qdef;
    else if (cx[`SFE_C_Z])
      d = sfe_edge(fmt, rs, 1'b1);
    else if (cx[`SFE_C_O])
    begin
      case (mode.rm)
        `SFE_RM_NEAR: d = sfe_edge(fmt, rs, 1'b1);
        `SFE_RM_ZERO: d = sfe_edge(fmt, rs, 1'b0);
        `SFE_RM_PLUS: d = sfe_edge(fmt, rs, !rs);
        default: d = sfe_edge(fmt, rs, rs);
      endcase
    end
    else
      d = rr;
    cause = cx & en6;
    eo.hit = (cause != 6'h00) && !mode.nx;
    if (cause == 6'h00)
    begin
      eo.acc = cx;
      eo.wr = 1'b1;
      eo.val = (cx == 6'h00) ? rr : d;
    end
    else if (!mode.nx)
    begin
      eo.acc = cx;
      eo.wr = 1'b0;
      eo.val = 64'h0;
    end
    else
    begin
      eo.acc = 6'h00;
      eo.wr = 1'b1;
      eo.val = sbase | {58'h0, cx};
    end
  end
endmodule

//--- bench/sfe_dpath_model.sv
// datapath side model: hands over one finished instruction at a time
// assumes: shares the unit clock; ready is looked at once it has settled
module sfe_dpath_model
  import sfe_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // instruction handshake
  input wire logic op_ready,
  output logic op_valid,
  output sfe_op_s op
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    op_valid = 1'b0;
    op = '0;
  end
  // gap idle cycles first, so both prompt and slow offers occur
  task automatic issue(input sfe_op_s o, input int gap, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op <= o;
    // taken at the rising edge that sees ready high; released right after it
    for (n = 0; n < 50 && !ok; n++)
    begin
      @(posedge ref_clk);
      ok = (op_ready === 1'b1);
    end
    op_valid <= 1'b0;
    // released lines carry garbage, never the last operands
    op <= ~o;
  endtask
endmodule

//--- bench/test_simd_fp_exception_result_logic.sv
// bench for the vector fp exception unit: cause, flags, trap, lane values
// assumes: sfe_pkg compiled first, datapath model alongside
`include "sfe_params.svh"
module test_simd_fp_exception_result_logic
  import sfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic op_valid;
  logic op_ready;
  sfe_op_s op;
  logic res_valid;
  logic [127:0] res_data;
  logic [7:0] res_wmask;
  logic simd_fp_trap;
  logic [4:0] trap_code;
  logic [5:0] trap_cause;
  int fail_count = 0;
  int tests_run = 0;
  int flags_m = 0;

  sfe_top u_sfe_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .op_valid(op_valid), .op_ready(op_ready), .op(op), .res_valid(res_valid),
    .res_data(res_data), .res_wmask(res_wmask), .simd_fp_trap(simd_fp_trap),
    .trap_code(trap_code), .trap_cause(trap_cause));
  sfe_dpath_model u_sfe_dpath_model (.ref_clk(ref_clk), .op_ready(op_ready),
    .op_valid(op_valid), .op(op));

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic results();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    results();
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------
  // avalon master and reference model
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address <= addr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // waitrequest and read data are looked at on the rising edge itself
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
      timeout();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // overflow default for 32-bit lanes; only rounding mode and sign matter
  function automatic logic [63:0] ovf(input logic [1:0] rm, input logic s);
    logic big;
    big = rm == `SFE_RM_ZERO || (rm == `SFE_RM_PLUS && s) || (rm == `SFE_RM_MINUS && !s);
    return {32'h0, s, big ? 31'h7F7FFFFF : 31'h7F800000};
  endfunction

  task automatic run_op(input sfe_fmt_t fmt, input logic [4:0] en, input logic nx,
                        input logic [1:0] rm, input logic [47:0] exc, input logic [127:0] r);
    sfe_op_s o;
    logic [31:0] rd;
    logic [31:0] cw;
    logic [127:0] mask;
    logic [63:0] lane;
    logic [63:0] rl;
    logic [63:0] snan;
    int n, w, i, c, en6, cause, wm, trap;
    bit ok;
    w = 8 << fmt;
    n = 128 / w;
    mask = (128'h1 << w) - 1;
    snan = fmt == `SFE_FMT_H ? `SFE_SNAN_H : fmt == `SFE_FMT_W ? `SFE_SNAN_W : `SFE_SNAN_D;
    o = '0;
    o.fmt = fmt;
    o.src_fmt = fmt;
    o.nsrc = 2'h2;
    o.cls.fp_dest = 1'b1;
    o.r = r;
    o.exc = exc;
    cw = {20'h0, rm, 1'b0, nx, 3'h0, en};
    bus(1'b1, `SFE_OFF_CTRL, cw, rd);
    bus(1'b0, `SFE_OFF_CTRL, 32'h0, rd);
    chk("ctrl", cw, rd);
    u_sfe_dpath_model.issue(o, $urandom % 3, ok);
    for (i = 0; i < 30 && res_valid !== 1'b1; i++)
      @(negedge ref_clk);
    if (!ok || res_valid !== 1'b1)
      timeout();
    cause = 0;
    wm = 0;
    trap = 0;
    en6 = {1'b1, en};
    for (i = 0; i < n; i++)
    begin
      c = exc[i*6 +: 6];
      if ((c & 4) != 0 && (en6 & 4) == 0) c |= 1;
      if ((c & 2) != 0 && (en6 & 2) == 0 && (c & 1) == 0) c ^= 2;
      lane = 64'((res_data >> (i * w)) & mask);
      rl = 64'((r >> (i * w)) & mask);
      if ((c & en6) == 0)
      begin
        cause |= c;
        wm |= 1 << i;
        // invalid and divide defaults depend on operands and go unchecked; overflow checked on 32-bit lanes only
        if ((c & 6'h18) == 0 && ((c & 4) == 0 || w == 32))
          chk("lane", (c & 4) != 0 ? ovf(rm, rl[31]) : rl, lane);
      end
      else if (!nx)
      begin
        cause |= c;
        trap = 1;
      end
      else
      begin
        wm |= 1 << i;
        chk("tagged nan", snan | c, lane);
      end
    end
    chk("wmask", wm, res_wmask);
    chk("trap", trap, simd_fp_trap);
    chk("trap cause", cause, trap_cause);
    if (trap)
      chk("trap code", `SFE_EXC_CODE, trap_code);
    else
      flags_m |= cause & 31;
    bus(1'b0, `SFE_OFF_FLAGS, 32'h0, rd);
    chk("flags", flags_m, rd);
    bus(1'b0, `SFE_OFF_CAUSE, 32'h0, rd);
    chk("cause", cause, rd);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int k;
    logic [31:0] rd;
    void'($urandom(75));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus(1'b0, `SFE_OFF_CTRL, 32'h0, rd);
    chk("ctrl reset", `SFE_CTRL_RST, rd);
    bus(1'b1, `SFE_OFF_CTRL, 32'hFFFFFFFF, rd);
    bus(1'b0, `SFE_OFF_CTRL, 32'h0, rd);
    chk("ctrl reserved", 32'h00000F1F, rd);
    for (k = 0; k < 8; k++)
      run_op(`SFE_FMT_W, 5'h00, 1'b0, k[1:0], 48'h4, {96'h0, k[2], 31'h3FABCDEF});
    run_op(`SFE_FMT_D, 5'h00, 1'b1, 2'h0, 48'h20, {4{32'h12345678}});
    run_op(`SFE_FMT_H, 5'h1F, 1'b0, 2'h0, 48'h0, {4{32'h3C003C00}});
    for (k = 0; k < 60; k++)
    begin
      run_op(2'($urandom_range(3, 1)), 5'($urandom), 1'($urandom), 2'($urandom),
             48'({$urandom & $urandom, $urandom & $urandom}), {4{$urandom}});
      if (k == 30)
      begin
        // write one to clear: sticky bits must drop only on request
        bus(1'b1, `SFE_OFF_FLAGS, 32'h1F, rd);
        flags_m = 0;
      end
    end
    results();
  end
endmodule
